// ===== hw/ldf_flags.sv
// diagnostic toggle, headroom and current-reached flags of a three channel led driver
// Functional notes
// - dimming input level change sets toggle flag
// - any write to toggle register clears all
// - headroom checked only when channel on, supply ok
// - low headroom forces channel gate low on the next clock edge
// - headroom warning set with gate forced low
// - switching resumes by itself once headroom returns
// - headroom warnings sticky until headroom register write
// - cleared warning resets from last sampled condition
// - reached-now flag sets when target current reached
// - reached-now cleared: dim fall, undervoltage, update request
// - reached-now cleared after gate and dim input both high 1 ms
// - toggle register layout, bit 6 reads one
// - headroom register layout, bits 7:6 zero
// - update request copies reached state, self-clears
// - supply ok follows threshold, fall is undervoltage
`timescale 1ns/10ps
`default_nettype none
`include "ldf_consts.svh"
module ldf_flags
  import ldf_pkg::*;
#(
  parameter int unsigned STUCK_CYCLES = `LDF_STUCK_CYCLES
)
(
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] dim_in_i,
  input  wire logic [2:0] chan_on_i,
  input  wire logic       supply_above_uv_i,
  input  wire logic [2:0] headroom_low_i,
  input  wire logic [2:0] current_reached_i,
  input  wire logic [2:0] gate_request_i,
  input  wire logic       reg_wr_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      toggle_reg_o,
  output logic [7:0]      headroom_reg_o,
  output logic [2:0]      reached_last_cycle_o,
  output logic [2:0]      update_req_o,
  output logic            supply_ok_flag_o,
  output logic [2:0]      gate_o
);

  ldf_chan_t dim_meta_q;
  ldf_chan_t dim_sync_q;
  ldf_chan_t dim_prev_q;
  ldf_chan_t toggled_q;
  ldf_chan_t warn_q;
  ldf_chan_t reached_now_q;
  ldf_chan_t reached_last_q;
  ldf_chan_t update_req_q;
  ldf_chan_t hr_sample_q;
  ldf_chan_t gate_q;
  logic      supply_ok_q;
  logic      supply_prev_q;

  logic      wr_toggle;
  logic      wr_headroom;
  logic      wr_update;
  logic      uv_event;
  ldf_chan_t dim_edge;
  ldf_chan_t dim_fall;
  ldf_chan_t hr_active;
  ldf_chan_t stuck;

  assign wr_toggle   = reg_wr_i && (reg_addr_i == `LDF_ADDR_TOGGLE);
  assign wr_headroom = reg_wr_i && (reg_addr_i == `LDF_ADDR_HEADROOM);
  assign wr_update   = reg_wr_i && (reg_addr_i == `LDF_ADDR_UPDATE_REQ);
  assign uv_event    = supply_prev_q && !supply_ok_q;
  assign dim_edge    = dim_sync_q ^ dim_prev_q;
  assign dim_fall    = dim_prev_q & ~dim_sync_q;
  assign hr_active   = chan_on_i & {3{supply_ok_q}} & headroom_low_i;

  // only the second stage and later look at the synchronised level
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dim_meta_q <= 3'h0;
      dim_sync_q <= 3'h0;
      dim_prev_q <= 3'h0;
    end
    else
    begin
      dim_meta_q <= dim_in_i;
      dim_sync_q <= dim_meta_q;
      dim_prev_q <= dim_sync_q;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      supply_ok_q   <= 1'b0;
      supply_prev_q <= 1'b0;
    end
    else
    begin
      supply_ok_q   <= supply_above_uv_i;
      supply_prev_q <= supply_ok_q;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      toggled_q <= 3'h0;
    else
      toggled_q <= (wr_toggle ? 3'h0 : toggled_q) | dim_edge;
  end

  // last sampled headroom state survives while the channel is not monitored
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hr_sample_q <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
        if (chan_on_i[i] && supply_ok_q)
          hr_sample_q[i] <= headroom_low_i[i];
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      warn_q <= 3'h0;
    else
      warn_q <= (wr_headroom ? 3'h0 : warn_q)
                | hr_active
                | (hr_sample_q & ~(chan_on_i & {3{supply_ok_q}}));
  end

  // gate registered from the same cause as the warning, so both move on one edge
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gate_q <= 3'h0;
    else
      gate_q <= gate_request_i & chan_on_i & {3{supply_ok_q}} & ~hr_active;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_stuck
      logic [$clog2(STUCK_CYCLES+1)-1:0] cnt_q;
      always_ff @(posedge clock_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          cnt_q <= '0;
        else if (!(gate_q[g] && dim_sync_q[g]))
          cnt_q <= '0;
        else if (cnt_q != STUCK_CYCLES[$clog2(STUCK_CYCLES+1)-1:0])
          cnt_q <= cnt_q + 1'b1;
      end
      assign stuck[g] = (cnt_q == STUCK_CYCLES[$clog2(STUCK_CYCLES+1)-1:0]);
    end
  endgenerate

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      update_req_q <= 3'h0;
    else
      update_req_q <= wr_update ? reg_wdata_i[2:0] : 3'h0;
  end

  // a clear outranks a new reach, the reach is sampled again next cycle
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reached_now_q <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
        if (dim_fall[i] || uv_event || update_req_q[i] || stuck[i])
          reached_now_q[i] <= 1'b0;
        else if (current_reached_i[i])
          reached_now_q[i] <= 1'b1;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reached_last_q <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
        if (uv_event || hr_active[i])
          reached_last_q[i] <= 1'b0;
        else if (update_req_q[i] || dim_fall[i])
          reached_last_q[i] <= reached_now_q[i];
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      toggle_reg_o         <= `LDF_TOGGLE_RSVD;
      headroom_reg_o       <= 8'h00;
      reached_last_cycle_o <= 3'h0;
      update_req_o         <= 3'h0;
      supply_ok_flag_o     <= 1'b0;
      gate_o               <= 3'h0;
    end
    else
    begin
      toggle_reg_o         <= `LDF_TOGGLE_RSVD | {5'h00, toggled_q};
      headroom_reg_o       <= {2'h0, reached_now_q, warn_q};
      reached_last_cycle_o <= reached_last_q;
      update_req_o         <= update_req_q;
      supply_ok_flag_o     <= supply_ok_q;
      gate_o               <= gate_q;
    end
  end

  // gate cut and warning land on the same edge, on every channel
  property gate_warn_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (|hr_active) |=> (((gate_q & $past(hr_active)) == 3'h0)
                        && ((warn_q & $past(hr_active)) == $past(hr_active)));
  endproperty
  gate_warn_a: assert property (gate_warn_p) else $error("gate not cut");
  property warn_sticky_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      !wr_headroom |=> ((warn_q & $past(warn_q)) == $past(warn_q));
  endproperty
  warn_sticky_a: assert property (warn_sticky_p) else $error("warning lost");
  property warn_wins_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_headroom && (|hr_active)) |=> ((warn_q & $past(hr_active)) == $past(hr_active));
  endproperty
  warn_wins_a: assert property (warn_wins_p) else $error("warning lost on clear");
  property hr_hold_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      !(chan_on_i[1] && supply_ok_q) |=> $stable(hr_sample_q[1]);
  endproperty
  hr_hold_a: assert property (hr_hold_p) else $error("headroom sampled while idle");
  property hr_resample_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_headroom && hr_sample_q[1] && !chan_on_i[1]) |=> warn_q[1];
  endproperty
  hr_resample_a: assert property (hr_resample_p) else $error("warning not re-set");
  property gate_resume_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (gate_request_i[1] && chan_on_i[1] && supply_ok_q && !headroom_low_i[1]) |=> gate_q[1];
  endproperty
  gate_resume_a: assert property (gate_resume_p) else $error("gate not resumed");
  property toggle_set_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (|dim_edge) |=> ((toggled_q & $past(dim_edge)) == $past(dim_edge));
  endproperty
  toggle_set_a: assert property (toggle_set_p) else $error("toggle missed");
  property toggle_clr_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_toggle |=> (toggled_q == $past(dim_edge));
  endproperty
  toggle_clr_a: assert property (toggle_clr_p) else $error("toggle not cleared");
  property sync_edge_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      $changed(dim_meta_q[0]) |=> dim_edge[0];
  endproperty
  sync_edge_a: assert property (sync_edge_p) else $error("pin change not seen");
  property toggle_rsvd_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      toggle_reg_o[7:3] == 5'h08;
  endproperty
  toggle_rsvd_a: assert property (toggle_rsvd_p) else $error("toggle reserved bits");
  property hr_rsvd_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      ##1 headroom_reg_o == {2'h0, $past(reached_now_q), $past(warn_q)};
  endproperty
  hr_rsvd_a: assert property (hr_rsvd_p) else $error("headroom register layout");
  property reach_set_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (current_reached_i[2] && !dim_fall[2] && !uv_event && !update_req_q[2] && !stuck[2])
        |=> reached_now_q[2];
  endproperty
  reach_set_a: assert property (reach_set_p) else $error("reach not flagged");
  property stuck_clr_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      stuck[2] |=> !reached_now_q[2];
  endproperty
  stuck_clr_a: assert property (stuck_clr_p) else $error("reach kept too long");
  sequence req_seq;
    wr_update && reg_wdata_i[0] ##1 (update_req_q[0] && !wr_update);
  endsequence
  property update_req_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      req_seq |=> (!reached_now_q[0] && !update_req_q[0]);
  endproperty
  update_req_a: assert property (update_req_p) else $error("update request");
  sequence copy_seq;
    update_req_q[0] && !uv_event && !hr_active[0];
  endsequence
  property last_copy_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      copy_seq |=> (reached_last_q[0] == $past(reached_now_q[0]));
  endproperty
  last_copy_a: assert property (last_copy_p) else $error("reach state not copied");
  property fall_clr_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      (|dim_fall) |=> ((reached_now_q & $past(dim_fall)) == 3'h0);
  endproperty
  fall_clr_a: assert property (fall_clr_p) else $error("reached not cleared on fall");
  property uv_clr_p;
    @(posedge clock_i) disable iff (!reset_n_i)
      uv_event |=> (reached_now_q == 3'h0);
  endproperty
  uv_clr_a: assert property (uv_clr_p) else $error("reached not cleared on uv");

endmodule : ldf_flags
`default_nettype wire

// ===== include/ldf_consts.svh
// constants of the led driver diagnostic flag bank
`ifndef LDF_CONSTS_SVH
`define LDF_CONSTS_SVH
`define LDF_ADDR_HEADROOM     7'h35
`define LDF_ADDR_TOGGLE       7'h36
`define LDF_ADDR_UPDATE_REQ   7'h06
`define LDF_TOGGLE_RSVD       8'h40
`define LDF_HR_REACHED_LSB    3
`define LDF_HR_WARN_LSB       0
`define LDF_STUCK_TIME_NS     1000000
`define LDF_CLK_PERIOD_NS     20
`define LDF_STUCK_CYCLES      ((`LDF_STUCK_TIME_NS + `LDF_CLK_PERIOD_NS - 1) / `LDF_CLK_PERIOD_NS)
`endif

// ===== include/ldf_pkg.sv
// types of the led driver diagnostic flag bank
package ldf_pkg;
  typedef logic [2:0] ldf_chan_t;
  typedef logic [7:0] ldf_byte_t;
endpackage : ldf_pkg

// ===== test/ldf_host_model.sv
// host side model that issues register writes to the flag bank
`timescale 1ns/10ps
`default_nettype none
module ldf_host_model
  import ldf_pkg::*;
(
  input  wire logic  clock_i,
  output logic       reg_wr_o,
  output logic [6:0] reg_addr_o,
  output ldf_byte_t  reg_wdata_o
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_addr_o  = 7'h00;
    reg_wdata_o = 8'h00;
  end
  // address and data are inverted after the strobe so that a late sample shows up
  task automatic wr(input logic [6:0] addr, input ldf_byte_t data);
    @(negedge clock_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    @(negedge clock_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask : wr
endmodule : ldf_host_model
`default_nettype wire

// ===== test/test_ldf_flags.sv
// self-checking bench of the diagnostic flag bank
`timescale 1ns/10ps
`default_nettype none
module test_ldf_flags
  import ldf_pkg::*;
;
  logic       clock_i, reset_n_i, supply, wr, sup_ok;
  logic [2:0] dim_in, chan_on, hr_low, cur_reach, gate_req, last, upd, gate;
  logic [6:0] addr;
  ldf_byte_t  wdata, tog_reg, hr_reg;
  int         n_errors, n_tests, cycles;

  ldf_host_model host_u (.clock_i(clock_i), .reg_wr_o(wr), .reg_addr_o(addr),
    .reg_wdata_o(wdata));
  // stuck time shortened so that the gate-high clear is reached quickly
  ldf_flags #(.STUCK_CYCLES(100)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .dim_in_i(dim_in), .chan_on_i(chan_on), .supply_above_uv_i(supply),
    .headroom_low_i(hr_low), .current_reached_i(cur_reach), .gate_request_i(gate_req),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .toggle_reg_o(tog_reg),
    .headroom_reg_o(hr_reg), .reached_last_cycle_o(last), .update_req_o(upd),
    .supply_ok_flag_o(sup_ok), .gate_o(gate));

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input ldf_byte_t seen, input ldf_byte_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    {reset_n_i, supply, dim_in, chan_on, hr_low, cur_reach, gate_req} = '0;
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    cyc(2);
    reset_n_i = 1'b1;
    check("tog_rst", tog_reg, 8'h40);
    check("hr_rst", hr_reg, 8'h00);
    dim_in = 3'h1;
    cyc(5);
    check("tog_one", tog_reg, 8'h41);
    dim_in = 3'h7;
    cyc(5);
    host_u.wr(7'h37, 8'hff);
    cyc(3);
    check("tog_all", tog_reg, 8'h47);
    host_u.wr(7'h36, 8'h00);
    cyc(3);
    check("tog_clr", tog_reg, 8'h40);
    supply = 1'b1;
    chan_on = 3'h7;
    gate_req = 3'h7;
    cyc(4);
    check("sup_ok", {7'h00, sup_ok}, 8'h01);
    check("gate_run", {5'h00, gate}, 8'h07);
    hr_low = 3'h2;
    cyc(3);
    check("gate_cut", {5'h00, gate}, 8'h05);
    check("hr_warn", hr_reg, 8'h02);
    chan_on = 3'h5;
    host_u.wr(7'h35, 8'h02);
    cyc(3);
    check("hr_reset", hr_reg, 8'h02);
    hr_low = 3'h0;
    chan_on = 3'h7;
    cyc(3);
    check("gate_back", {5'h00, gate}, 8'h07);
    check("hr_sticky", hr_reg, 8'h02);
    host_u.wr(7'h35, 8'h00);
    cyc(3);
    check("hr_clr", hr_reg, 8'h00);
    cur_reach = 3'h7;
    cyc(1);
    cur_reach = 3'h0;
    cyc(3);
    check("reach_set", hr_reg, 8'h38);
    host_u.wr(7'h06, 8'h01);
    cyc(1);
    check("upd_pulse", {5'h00, upd}, 8'h01);
    cyc(3);
    check("reach_upd", hr_reg, 8'h30);
    check("last_copy", {5'h00, last}, 8'h01);
    check("upd_self_clr", {5'h00, upd}, 8'h00);
    dim_in = 3'h5;
    cyc(6);
    check("reach_dim", hr_reg, 8'h20);
    check("last_fall", {5'h00, last}, 8'h03);
    supply = 1'b0;
    cyc(4);
    check("reach_uv", hr_reg, 8'h00);
    check("last_uv", {5'h00, last}, 8'h00);
    check("sup_low", {7'h00, sup_ok}, 8'h00);
    supply = 1'b1;
    cyc(3);
    cur_reach = 3'h4;
    cyc(1);
    cur_reach = 3'h0;
    cyc(3);
    check("reach_again", hr_reg, 8'h20);
    cyc(110);
    check("reach_stuck", hr_reg, 8'h00);
    // one-cycle low headroom lands on the same edge as the clearing write
    fork
      host_u.wr(7'h35, 8'h01);
      begin
        @(negedge clock_i);
        hr_low = 3'h1;
        @(negedge clock_i);
        hr_low = 3'h0;
      end
    join
    cyc(1);
    check("gate_pulse", {5'h00, gate}, 8'h06);
    cyc(2);
    check("hr_wins", hr_reg, 8'h01);
    stop_test();
  end
endmodule : test_ldf_flags
`default_nettype wire
